// >>> src/pad_pkg.sv
package pad_pkg;

  // APB geometry
  localparam int unsigned APB_AW = 12;
  localparam int unsigned APB_DW = 32;

  // Register byte addresses
  localparam logic [APB_AW-1:0] CTRL_ADDR   = 12'h000;
  localparam logic [APB_AW-1:0] STATUS_ADDR = 12'h004;

  // Control register layout
  localparam int unsigned CTRL_W      = 10;
  localparam int unsigned F_DUAL_RX   = 0;  // Dual-edge receive
  localparam int unsigned F_DUAL_TX   = 1;  // Dual-edge transmit
  localparam int unsigned F_RESYNC    = 2;  // Realign both bits to rising edge
  localparam int unsigned F_RX_REG    = 3;  // Register the receive path
  localparam int unsigned F_TX_REG    = 4;  // Register the transmit path
  localparam int unsigned F_OE_REG    = 5;  // Register the drive enable
  localparam int unsigned F_TX_INV    = 6;  // Invert transmit data
  localparam int unsigned F_RX_FALL   = 7;  // Receive register on falling edge
  localparam int unsigned F_TX_FALL   = 8;  // Transmit register on falling edge
  localparam int unsigned F_OE_FALL   = 9;  // Drive-enable register on falling edge
  localparam logic [CTRL_W-1:0] CTRL_RST = 10'h000;

  // Status register layout
  localparam int unsigned S_PAD_IN    = 0;
  localparam int unsigned S_RX_LSB    = 1;
  localparam int unsigned S_RX_MSB    = 2;
  localparam int unsigned S_NO_DUAL   = 3;
  localparam int unsigned S_OE        = 4;
  localparam int unsigned S_PAD_OUT   = 5;

  localparam logic [APB_DW-1:0] RDATA_RST = 32'h0000_0000;

endpackage : pad_pkg

// >>> src/edge_sense.sv
`timescale 1ns/1ps
`default_nettype none
module edge_sense
(
  input  wire logic ref_clk_i,
  input  wire logic rst_i,
  input  wire logic level_i,
  output logic      rise_o,
  output logic      fall_o
);

  logic prev_ff;
  logic nxt_prev;

  // Previous level of the core clock input
  always_comb
  begin
    nxt_prev = level_i;
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      prev_ff <= 1'b0;
    else
      prev_ff <= nxt_prev;
  end

  // One-cycle edge pulses
  assign rise_o = level_i & ~prev_ff;
  assign fall_o = ~level_i & prev_ff;

endmodule : edge_sense
`default_nettype wire

// >>> src/dual_edge_pad_io_logic.sv
// Notes on behaviour
// - Single-rate mode: pad value reaches the core on receive bit 0.
// - Dual-edge receive: rising sample on bit 0, falling sample on bit 1.
// - Dual-edge transmit: bit 0 driven at rising edge, bit 1 at falling edge.
// - Bypass path carries the pad value unregistered to clock and reference nets.
// - Core drive enable controls the pad driver, optionally registered.
// - Transmit and drive-enable registers run on the transmit register clock.
// - Receive registers run on the separate receive register clock.
// - Dual-edge mode samples both edges, two bits per clock cycle.
// - Without resync each bit is exchanged at its own sampling or launch edge.
// - Resync exchanges both dual-edge bits on the rising edge only.
// - Resync delays the falling receive sample half a period to the next rise.
// - Pads on differential resources used single-ended get no dual-edge mode.
// - Every single-rate register can trigger on rising or falling edge of its clock; dual-edge bits keep fixed edges.
// - Transmit register may invert the data driven onto the pad.
`timescale 1ns/1ps
`default_nettype none
module dual_edge_pad_io_logic
  import pad_pkg::*;
#(
  parameter bit DIFF_SINGLE_ENDED = 1'b0
)
(
  input  wire logic              ref_clk_i,
  input  wire logic              rst_i,
  // APB slave
  input  wire logic [APB_AW-1:0] paddr_i,
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [APB_DW-1:0] pwdata_i,
  output logic      [APB_DW-1:0] prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  // Core side
  input  wire logic              tx_reg_clock_i,
  input  wire logic              rx_reg_clock_i,
  input  wire logic [1:0]        tx_data_i,
  input  wire logic              drive_en_i,
  output logic      [1:0]        rx_data_o,
  output logic                   bypass_path_o,
  // Pad
  input  wire logic              pad_in_i,
  output logic                   pad_out_o,
  output logic                   pad_oe_n_o
);

  // Pick the edge pulse chosen by a trigger-select bit
  function automatic logic pick_edge(input logic rise, input logic fall, input logic use_fall);
    pick_edge = use_fall ? fall : rise;
  endfunction : pick_edge

  logic [CTRL_W-1:0] ctrl_ff;
  logic [CTRL_W-1:0] nxt_ctrl;
  logic [APB_DW-1:0] prdata_ff;
  logic [APB_DW-1:0] nxt_prdata;
  logic [1:0]        rx_ff;
  logic [1:0]        nxt_rx;
  logic              fall_hold_ff;
  logic              nxt_fall_hold;
  logic              pad_ff;
  logic              nxt_pad;
  logic              tx_late_ff;
  logic              nxt_tx_late;
  logic              oe_ff;
  logic              nxt_oe;
  logic              rx_rise;
  logic              rx_fall;
  logic              tx_rise;
  logic              tx_fall;
  logic              dual_rx;
  logic              dual_tx;
  logic              resync;
  logic              tx_inv;
  logic              addr_ctrl;
  logic              addr_status;
  logic              access;
  logic [APB_DW-1:0] read_mux;

  // Edge pulses of the two core register clocks
  edge_sense u_tx_edges
  (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .level_i   (tx_reg_clock_i),
    .rise_o    (tx_rise),
    .fall_o    (tx_fall)
  );

  edge_sense u_rx_edges
  (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .level_i   (rx_reg_clock_i),
    .rise_o    (rx_rise),
    .fall_o    (rx_fall)
  );

  // Mode decode; dual-edge barred on differential pads
  assign dual_rx = ctrl_ff[F_DUAL_RX] & ~DIFF_SINGLE_ENDED;
  assign dual_tx = ctrl_ff[F_DUAL_TX] & ~DIFF_SINGLE_ENDED;
  assign resync  = ctrl_ff[F_RESYNC];
  assign tx_inv  = ctrl_ff[F_TX_INV];

  // APB decode
  assign addr_ctrl   = (paddr_i == CTRL_ADDR);
  assign addr_status = (paddr_i == STATUS_ADDR);
  assign access      = psel_i & penable_i;

  always_comb
  begin
    read_mux = RDATA_RST;
    if (addr_ctrl)
      read_mux[CTRL_W-1:0] = ctrl_ff;
    else if (addr_status)
    begin
      read_mux[S_PAD_IN]           = pad_in_i;
      read_mux[S_RX_MSB:S_RX_LSB]  = rx_ff;
      read_mux[S_NO_DUAL]          = DIFF_SINGLE_ENDED;
      read_mux[S_OE]               = oe_ff;
      read_mux[S_PAD_OUT]          = pad_ff;
    end
  end

  // Register writes in the access cycle, read capture in the setup cycle
  always_comb
  begin
    nxt_ctrl   = ctrl_ff;
    nxt_prdata = prdata_ff;
    if (psel_i && !penable_i)
      nxt_prdata = read_mux;
    if (access && pwrite_i && addr_ctrl)
      nxt_ctrl = pwdata_i[CTRL_W-1:0];
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ctrl_ff   <= CTRL_RST;
      prdata_ff <= RDATA_RST;
    end
    else
    begin
      ctrl_ff   <= nxt_ctrl;
      prdata_ff <= nxt_prdata;
    end
  end

  assign prdata_o  = prdata_ff;
  assign pready_o  = access;
  assign pslverr_o = access & ~addr_ctrl & ~addr_status;

  // Receive path on receive clock edges
  always_comb
  begin
    nxt_rx        = rx_ff;
    nxt_fall_hold = fall_hold_ff;
    if (dual_rx)
    begin
      if (resync)
      begin
        if (rx_fall)
          nxt_fall_hold = pad_in_i;
        if (rx_rise)
          nxt_rx = {fall_hold_ff, pad_in_i};
      end
      else
      begin
        if (rx_rise)
          nxt_rx[0] = pad_in_i;
        if (rx_fall)
          nxt_rx[1] = pad_in_i;
      end
    end
    else
    begin
      nxt_rx[1] = 1'b0;
      if (!ctrl_ff[F_RX_REG] || pick_edge(rx_rise, rx_fall, ctrl_ff[F_RX_FALL]))
        nxt_rx[0] = pad_in_i;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rx_ff        <= 2'h0;
      fall_hold_ff <= 1'b0;
    end
    else
    begin
      rx_ff        <= nxt_rx;
      fall_hold_ff <= nxt_fall_hold;
    end
  end

  assign rx_data_o = rx_ff;

  // Transmit and drive-enable path on transmit clock edges
  always_comb
  begin
    nxt_pad     = pad_ff;
    nxt_tx_late = tx_late_ff;
    nxt_oe      = oe_ff;
    if (dual_tx)
    begin
      if (tx_rise)
      begin
        nxt_pad     = tx_data_i[0] ^ tx_inv;
        nxt_tx_late = tx_data_i[1];
      end
      if (tx_fall)
        nxt_pad = (resync ? tx_late_ff : tx_data_i[1]) ^ tx_inv;
    end
    else if (!ctrl_ff[F_TX_REG] || pick_edge(tx_rise, tx_fall, ctrl_ff[F_TX_FALL]))
      nxt_pad = tx_data_i[0] ^ tx_inv;
    if (!ctrl_ff[F_OE_REG] || pick_edge(tx_rise, tx_fall, ctrl_ff[F_OE_FALL]))
      nxt_oe = drive_en_i;
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pad_ff     <= 1'b0;
      tx_late_ff <= 1'b0;
      oe_ff      <= 1'b0;
    end
    else
    begin
      pad_ff     <= nxt_pad;
      tx_late_ff <= nxt_tx_late;
      oe_ff      <= nxt_oe;
    end
  end

  // Pad driver and bypass
  assign pad_out_o     = pad_ff;
  assign pad_oe_n_o    = ~oe_ff;
  assign bypass_path_o = pad_in_i;

  // Checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_resync_fall;
    dual_rx && resync && rx_fall;
  endsequence

  sequence s_resync_rise;
    dual_rx && resync && rx_rise;
  endsequence

  sequence s_tx_resync_rise;
    dual_tx && resync && tx_rise;
  endsequence

  sequence s_tx_resync_fall;
    dual_tx && resync && tx_fall;
  endsequence

  chk_bypass_follow: assert property (bypass_path_o == pad_in_i)
    else $error("bypass path does not follow pad");

  chk_single_rate_rx: assert property (!dual_rx && ctrl_ff[F_RX_REG] && !ctrl_ff[F_RX_FALL] && rx_rise
    |=> rx_data_o == {1'b0, $past(pad_in_i)})
    else $error("single-rate receive bit wrong");

  chk_rx_fall_trig: assert property (!dual_rx && ctrl_ff[F_RX_REG] && ctrl_ff[F_RX_FALL] && rx_fall
    |=> rx_data_o[0] == $past(pad_in_i))
    else $error("falling-edge receive register missed");

  chk_dual_rx_rise: assert property (dual_rx && !resync && rx_rise
    |=> rx_data_o[0] == $past(pad_in_i) && $stable(rx_data_o[1]))
    else $error("dual-edge rising sample wrong");

  chk_dual_rx_fall: assert property (dual_rx && !resync && rx_fall
    |=> rx_data_o[1] == $past(pad_in_i))
    else $error("dual-edge falling sample not delivered at its edge");

  chk_resync_stable: assert property (s_resync_fall ##1 (!rx_rise) [*1] |-> $stable(rx_data_o))
    else $error("resync output moved off rising edge");

  // Fall, three quiet cycles, then rise: the fall sample surfaces after the rise
  chk_resync_delay: assert property (s_resync_fall ##1 (!rx_fall && !rx_rise) [*3] ##1 s_resync_rise
    |=> rx_data_o[1] == $past(pad_in_i, 5))
    else $error("resync falling sample not carried to next rise");

  // Resync transmit: bit 1 taken at the rise is driven at the following fall
  chk_tx_resync_fall: assert property (s_tx_resync_rise ##1 (!tx_fall && !tx_rise) [*3] ##1 s_tx_resync_fall
    |=> pad_out_o == ($past(tx_data_i[1], 5) ^ $past(tx_inv, 5)))
    else $error("resync transmit bit 1 not taken at rise");

  chk_tx_dual_rise: assert property (dual_tx && tx_rise
    |=> pad_out_o == ($past(tx_data_i[0]) ^ $past(tx_inv)))
    else $error("dual-edge transmit bit 0 wrong");

  chk_tx_dual_fall: assert property (dual_tx && !resync && tx_fall
    |=> pad_out_o == ($past(tx_data_i[1]) ^ $past(tx_inv)))
    else $error("dual-edge transmit bit 1 wrong");

  chk_oe_register: assert property (ctrl_ff[F_OE_REG] && !ctrl_ff[F_OE_FALL] && tx_rise
    |=> pad_oe_n_o == !$past(drive_en_i))
    else $error("registered drive enable wrong");

  chk_oe_release: assert property (!drive_en_i && !ctrl_ff[F_OE_REG] |=> pad_oe_n_o)
    else $error("pad driver not released");

  chk_no_diff_dual: assert property (DIFF_SINGLE_ENDED |-> !dual_rx && !dual_tx)
    else $error("dual-edge active on differential pad");

endmodule : dual_edge_pad_io_logic
`default_nettype wire

// >>> verif/pad_board_model.sv
`timescale 1ns/1ps
`default_nettype none
module pad_board_model
(
  input  wire logic pad_out_i,
  input  wire logic pad_oe_n_i,
  input  wire logic board_en_i,
  input  wire logic board_val_i,
  output logic      pad_level_o
);
  // Pad wire: contention unknown, then driver, then board, else pull-up
  always_comb
  begin
    if (!pad_oe_n_i && board_en_i)
      pad_level_o = 1'bx;
    else if (!pad_oe_n_i)
      pad_level_o = pad_out_i;
    else if (board_en_i)
      pad_level_o = board_val_i;
    else
      pad_level_o = 1'b1;
  end
endmodule : pad_board_model
`default_nettype wire

// >>> verif/dual_edge_pad_io_logic_tb.sv
`timescale 1ns/1ps
`default_nettype none
module dual_edge_pad_io_logic_tb
  import pad_pkg::*;
;
  logic              ref_clk_i;
  logic              rst_i;
  logic [APB_AW-1:0] paddr;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [APB_DW-1:0] pwdata;
  logic [APB_DW-1:0] prdata;
  logic              pready;
  logic              pslverr;
  logic              last_err;
  logic              tx_clk;
  logic              rx_clk;
  logic [1:0]        tx_data;
  logic              drive_en;
  logic [1:0]        rx_data;
  logic              bypass;
  logic              pad_in;
  logic              pad_out;
  logic              pad_oe_n;
  logic              board_en;
  logic              board_val;
  int                errors;
  int                check_count;
  int                cycles;

  dual_edge_pad_io_logic dual_edge_pad_io_logic_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .paddr_i(paddr),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .tx_reg_clock_i(tx_clk), .rx_reg_clock_i(rx_clk),
    .tx_data_i(tx_data), .drive_en_i(drive_en), .rx_data_o(rx_data), .bypass_path_o(bypass),
    .pad_in_i(pad_in), .pad_out_o(pad_out), .pad_oe_n_o(pad_oe_n));

  pad_board_model pad_board_model_inst (.pad_out_i(pad_out), .pad_oe_n_i(pad_oe_n),
    .board_en_i(board_en), .board_val_i(board_val), .pad_level_o(pad_in));

  // Clock, 100 ns period
  initial
  begin
    ref_clk_i = 1'b0;
    forever #50 ref_clk_i = ~ref_clk_i;
  end

  // Hang guard
  always @(posedge ref_clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles >= 5000)
    begin
      errors = errors + 1;
      end_of_test();
    end
  end

  task end_of_test();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test

  task chk(input string nm, input logic [APB_DW-1:0] exp, input logic [APB_DW-1:0] got);
    check_count = check_count + 1;
    if (got !== exp)
    begin
      $display("BAD %s expected %h seen %h", nm, exp, got);
      errors = errors + 1;
    end
  endtask : chk

  task c1(input string nm, input logic exp, input logic got);
    chk(nm, {31'h0, exp}, {31'h0, got});
  endtask : c1

  task cr(input logic [1:0] exp);
    chk("rx_data", {30'h0, exp}, {30'h0, rx_data});
  endtask : cr

  // One APB transfer, held until pready
  task apb(input logic w, input logic [APB_AW-1:0] a, input logic [APB_DW-1:0] d, output logic [APB_DW-1:0] q);
    @(posedge ref_clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk_i);
    penable <= 1'b1;
    // Ends when pready rises; the hang guard ends it if pready never comes
    do
    begin
      @(posedge ref_clk_i);
    end
    while (pready !== 1'b1);
    q = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [APB_DW-1:0] d);
    logic [APB_DW-1:0] q;
    apb(1'b1, CTRL_ADDR, d, q);
  endtask : wr

  task rd(input logic [APB_AW-1:0] a, input logic [APB_DW-1:0] exp);
    logic [APB_DW-1:0] q;
    apb(1'b0, a, 32'h0, q);
    chk("prdata", exp, q);
  endtask : rd

  // Drive core clocks, data and board, then let it settle
  task step(input int rc, input int tc, input logic [1:0] td, input int de, input int be, input int bv);
    @(posedge ref_clk_i);
    rx_clk <= rc[0];
    tx_clk <= tc[0];
    tx_data <= td;
    drive_en <= de[0];
    board_en <= be[0];
    board_val <= bv[0];
    repeat (3) @(posedge ref_clk_i);
    #1;
  endtask : step

  // Main sequence
  initial
  begin
    logic [APB_DW-1:0] q;
    {rst_i, psel, penable, pwrite, paddr, pwdata} = {1'b1, 47'h0};
    {tx_clk, rx_clk, tx_data, drive_en, board_en, board_val} = 7'h00;
    {errors, check_count, cycles} = {32'h0, 32'h0, 32'h0};
    repeat (4) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    rd(CTRL_ADDR, 32'h0);
    rd(12'h010, 32'h0);
    c1("pslverr", 1'b1, last_err);
    wr(32'hffff_ffff);
    rd(CTRL_ADDR, 32'h0000_03ff);
    apb(1'b0, STATUS_ADDR, 32'h0, q);
    c1("no_dual_edge", 1'b0, q[S_NO_DUAL]);
    // Single rate receive and bypass
    wr(32'h0);
    step(0, 0, 2'b00, 0, 1, 1); cr(2'b01);
    @(posedge ref_clk_i);
    board_val <= 1'b0;
    #1 c1("bypass", 1'b0, bypass);
    // Registered receive on its own clock, edge select
    wr(32'h8);
    step(0, 0, 2'b00, 0, 1, 1); cr(2'b00);
    step(0, 1, 2'b00, 0, 1, 1); cr(2'b00);
    step(1, 1, 2'b00, 0, 1, 1); cr(2'b01);
    wr(32'h88);
    step(0, 0, 2'b00, 0, 1, 0); cr(2'b00);
    step(1, 0, 2'b00, 0, 1, 1); cr(2'b00);
    step(0, 0, 2'b00, 0, 1, 1); cr(2'b01);
    // Dual-edge receive without and with resync
    wr(32'h89);
    step(1, 0, 2'b00, 0, 1, 0);
    step(0, 0, 2'b00, 0, 1, 1); cr(2'b10);
    step(1, 0, 2'b00, 0, 1, 1); cr(2'b11);
    step(0, 0, 2'b00, 0, 1, 0); cr(2'b01);
    wr(32'h8d);
    step(1, 0, 2'b00, 0, 1, 1);
    step(0, 0, 2'b00, 0, 1, 0);
    step(1, 0, 2'b00, 0, 1, 1); cr(2'b01);
    step(0, 0, 2'b00, 0, 1, 1); cr(2'b01);
    step(1, 0, 2'b00, 0, 1, 0); cr(2'b10);
    // Dual-edge transmit, inversion, resync
    wr(32'h2);
    step(1, 1, 2'b10, 1, 0, 0); c1("pad_out", 1'b0, pad_out);
    c1("pad_oe_n", 1'b0, pad_oe_n);
    step(1, 0, 2'b10, 1, 0, 0); c1("pad_out", 1'b1, pad_out);
    step(1, 1, 2'b01, 1, 0, 0); c1("pad_out", 1'b1, pad_out);
    step(1, 0, 2'b11, 1, 0, 0); c1("pad_out", 1'b1, pad_out);
    wr(32'h42);
    step(1, 1, 2'b10, 1, 0, 0); c1("pad_out", 1'b1, pad_out);
    step(1, 0, 2'b10, 1, 0, 0); c1("pad_out", 1'b0, pad_out);
    wr(32'h6);
    step(1, 1, 2'b10, 1, 0, 0); c1("pad_out", 1'b0, pad_out);
    step(1, 0, 2'b00, 1, 0, 0); c1("pad_out", 1'b1, pad_out);
    // Registered drive enable on the transmit clock, then release
    wr(32'h30);
    step(1, 0, 2'b00, 0, 0, 0); c1("pad_oe_n", 1'b0, pad_oe_n);
    step(0, 0, 2'b00, 0, 0, 0); c1("pad_oe_n", 1'b0, pad_oe_n);
    step(0, 1, 2'b00, 0, 0, 0); c1("pad_oe_n", 1'b1, pad_oe_n);
    step(0, 1, 2'b00, 0, 1, 0); c1("bypass", 1'b0, bypass);
    // Mid-run reset: driver released, control register cleared
    @(posedge ref_clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    #1 c1("pad_oe_n", 1'b1, pad_oe_n);
    cr(2'b00);
    @(posedge ref_clk_i);
    rst_i <= 1'b0;
    rd(CTRL_ADDR, 32'h0);
    end_of_test();
  end
endmodule : dual_edge_pad_io_logic_tb
`default_nettype wire
